// [rtl/intvec_pkg.sv]
// Shared constants, types and the vector gate leaf for the interrupt block
package intvec_pkg;

    // ************************************************************
    // Source indices in default order (index 0 wins ties)
    // ************************************************************
    localparam int          NUM_SRC   = 48;
    localparam int          NUM_PER   = 31;
    localparam int          NUM_PRIO  = 13;
    localparam logic [5:0]  IDX_NMI   = 6'h00;
    localparam logic [5:0]  IDX_EXT   = 6'h01;
    localparam logic [5:0]  IDX_SWDT  = 6'h09;
    localparam logic [5:0]  IDX_WDT   = 6'h0A;
    localparam logic [5:0]  IDX_TMR0  = 6'h0B;
    localparam logic [5:0]  IDX_TMR1  = 6'h10;
    localparam logic [5:0]  IDX_TMR2  = 6'h14;
    localparam logic [5:0]  IDX_DMA   = 6'h18;
    localparam logic [5:0]  IDX_SER0  = 6'h1C;
    localparam logic [5:0]  IDX_SER1  = 6'h20;
    localparam logic [5:0]  IDX_SER2  = 6'h24;
    localparam logic [5:0]  IDX_EXP   = 6'h28;

    // ************************************************************
    // Vector numbers, first vector of each group
    // ************************************************************
    localparam logic [7:0]  VEC_NMI   = 8'h07;
    localparam logic [7:0]  VEC_EXT   = 8'h10;
    localparam logic [7:0]  VEC_SWDT  = 8'h18;
    localparam logic [7:0]  VEC_WDT   = 8'h19;
    localparam logic [7:0]  VEC_TMR0  = 8'h20;
    localparam logic [7:0]  VEC_TMR1  = 8'h28;
    localparam logic [7:0]  VEC_TMR2  = 8'h2C;
    localparam logic [7:0]  VEC_DMA   = 8'h48;
    localparam logic [7:0]  VEC_SER0  = 8'h50;
    localparam logic [7:0]  VEC_SER1  = 8'h54;
    localparam logic [7:0]  VEC_SER2  = 8'h58;
    localparam logic [7:0]  VEC_EXP   = 8'h68;

    // ************************************************************
    // Priority field index: register*2, plus 1 for the lower field
    // ************************************************************
    localparam logic [4:0]  FLD_SWDT  = 5'h05;
    localparam logic [4:0]  FLD_WDT   = 5'h06;
    localparam logic [4:0]  FLD_TMR0  = 5'h0A;
    localparam logic [4:0]  FLD_TMR1  = 5'h0B;
    localparam logic [4:0]  FLD_TMR2  = 5'h0C;
    localparam logic [4:0]  FLD_DMA   = 5'h12;
    localparam logic [4:0]  FLD_SER0  = 5'h13;
    localparam logic [4:0]  FLD_SER1  = 5'h14;
    localparam logic [4:0]  FLD_SER2  = 5'h15;
    localparam logic [4:0]  FLD_EXPHI = 5'h18;
    localparam logic [4:0]  FLD_EXPLO = 5'h19;
    localparam int          UPPER_MSB = 6;
    localparam int          UPPER_LSB = 4;
    localparam int          LOWER_MSB = 2;
    localparam int          LOWER_LSB = 0;
    localparam logic [3:0]  NMI_LEVEL = 4'h8;
    localparam logic [2:0]  RST_MASK  = 3'h7;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef logic [NUM_PRIO-1:0][7:0] prio_regs_t;

    typedef struct packed {
        logic [NUM_PER-1:0] flag;
        logic [NUM_PER-1:0] enable;
    } periph_req_t;

    typedef struct packed {
        logic        issue_core;
        logic        issue_xfer;
        logic [7:0]  vector;
        logic [15:0] address;
    } vector_out_t;

    // ************************************************************
    // Decoders shared by the arbiter and the gate
    // ************************************************************
    function automatic logic [7:0] src_vector(input logic [5:0] idx);
        logic [7:0] v;
        v = VEC_NMI;
        if (idx >= IDX_EXP)
            v = VEC_EXP + 8'(idx - IDX_EXP);
        else if (idx >= IDX_SER2)
            v = VEC_SER2 + 8'(idx - IDX_SER2);
        else if (idx >= IDX_SER1)
            v = VEC_SER1 + 8'(idx - IDX_SER1);
        else if (idx >= IDX_SER0)
            v = VEC_SER0 + 8'(idx - IDX_SER0);
        else if (idx >= IDX_DMA)
            v = VEC_DMA + 8'(idx - IDX_DMA);
        else if (idx >= IDX_TMR2)
            v = VEC_TMR2 + 8'(idx - IDX_TMR2);
        else if (idx >= IDX_TMR1)
            v = VEC_TMR1 + 8'(idx - IDX_TMR1);
        else if (idx >= IDX_TMR0)
            v = VEC_TMR0 + 8'(idx - IDX_TMR0);
        else if (idx == IDX_WDT)
            v = VEC_WDT;
        else if (idx == IDX_SWDT)
            v = VEC_SWDT;
        else if (idx >= IDX_EXT)
            v = VEC_EXT + 8'(idx - IDX_EXT);
        return v;
    endfunction

    function automatic logic [4:0] src_field(input logic [5:0] idx);
        logic [4:0] f;
        logic [2:0] n;
        n = 3'(idx - IDX_EXT);
        f = 5'h00;
        if (idx >= IDX_EXP + 6'h04)
            f = FLD_EXPLO;
        else if (idx >= IDX_EXP)
            f = FLD_EXPHI;
        else if (idx >= IDX_SER2)
            f = FLD_SER2;
        else if (idx >= IDX_SER1)
            f = FLD_SER1;
        else if (idx >= IDX_SER0)
            f = FLD_SER0;
        else if (idx >= IDX_DMA)
            f = FLD_DMA;
        else if (idx >= IDX_TMR2)
            f = FLD_TMR2;
        else if (idx >= IDX_TMR1)
            f = FLD_TMR1;
        else if (idx >= IDX_TMR0)
            f = FLD_TMR0;
        else if (idx == IDX_WDT)
            f = FLD_WDT;
        else if (idx == IDX_SWDT)
            f = FLD_SWDT;
        else if (idx >= IDX_EXT)
            f = (n < 3'h2) ? {2'h0, n} : 5'({2'h0, n[2:1]} + 5'h01);
        return f;
    endfunction

endpackage

`timescale 1ns/10ps

// ************************************************************
// Mask comparison and vector address forming for the winner
// ************************************************************
module vector_gate
(
    input  wire logic                      found_i,
    input  wire logic [5:0]                idx_i,
    input  wire logic [3:0]                level_i,
    input  wire logic [2:0]                mask_level_i,
    input  wire logic                      xfer_route_i,
    output intvec_pkg::vector_out_t        out_o
);

    logic [7:0] vec;
    logic       above;

    assign vec   = intvec_pkg::src_vector(idx_i);
    // Non-maskable source passes whatever the mask says
    assign above = found_i && ((idx_i == intvec_pkg::IDX_NMI) ||
                   (level_i > {1'b0, mask_level_i}));

    // Transfer activation leaves the core untouched
    assign out_o.issue_core = above && !xfer_route_i;
    assign out_o.issue_xfer = above && xfer_route_i;
    assign out_o.vector     = vec;
    assign out_o.address    = {6'h00, vec, 2'h0};

endmodule

// [rtl/interrupt_vector_priority.sv]
// Priority arbitration and vector generation for the interrupt controller
`timescale 1ns/10ps

module interrupt_vector_priority
(
    input  wire logic                              mclk_i,
    input  wire logic                              rstn_i,
    input  wire logic                              nmi_event_i,
    input  wire logic [7:0]                        ext_pin_req_i,
    input  wire logic [7:0]                        expansion_request_pin_n_i,
    input  wire intvec_pkg::periph_req_t           periph_req_i,
    input  wire logic [intvec_pkg::NUM_PER-1:0]    xfer_route_i,
    input  wire intvec_pkg::prio_regs_t            priority_level_register_i,
    input  wire logic [2:0]                        mask_level_i,
    input  wire logic                              core_ack_i,
    output logic                                   core_irq_o,
    output logic                                   xfer_req_o,
    output logic [7:0]                             vector_num_o,
    output logic [15:0]                            vector_addr_o
);

    // ************************************************************
    // Pending vector in default order
    // ************************************************************
    logic                                nmi_pend_q;
    logic                                nmi_taken;
    logic [intvec_pkg::NUM_SRC-1:0]      pend;
    logic [intvec_pkg::NUM_PER-1:0]      periph_pend;

    assign periph_pend = periph_req_i.flag & periph_req_i.enable;

    always_comb
    begin
        pend                        = '0;
        pend[intvec_pkg::IDX_NMI]   = nmi_pend_q;
        pend[8:1]                   = ext_pin_req_i;
        pend[39:9]                  = periph_pend;
        pend[47:40]                 = ~expansion_request_pin_n_i;
    end

    // NMI is an event; it stays latched until the core accepts it
    assign nmi_taken = core_ack_i && core_irq_o &&
                       (vector_num_o == intvec_pkg::VEC_NMI);

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            nmi_pend_q <= 1'b0;
        else if (nmi_event_i)
            nmi_pend_q <= 1'b1;
        else if (nmi_taken)
            nmi_pend_q <= 1'b0;
    end

    // ************************************************************
    // Level of each source from its priority field; NMI fixed at NMI_LEVEL
    // ************************************************************
    function automatic logic [3:0] field_level
    (
        input intvec_pkg::prio_regs_t regs,
        input logic [4:0]             fld
    );
        logic [7:0] r;
        logic [2:0] v;
        r = regs[fld[4:1]];
        if (fld[0])
            v = r[intvec_pkg::LOWER_MSB:intvec_pkg::LOWER_LSB];
        else
            v = r[intvec_pkg::UPPER_MSB:intvec_pkg::UPPER_LSB];
        return {1'b0, v};
    endfunction

    logic [intvec_pkg::NUM_SRC-1:0][3:0] level;

    generate
        for (genvar g = 0; g < intvec_pkg::NUM_SRC; g++)
        begin : g_level
            if (g == 0)
            begin : g_nmi
                assign level[g] = intvec_pkg::NMI_LEVEL;
            end
            else
            begin : g_src
                assign level[g] = field_level(priority_level_register_i,
                                  intvec_pkg::src_field(6'(g)));
            end
        end
    endgenerate

    // ************************************************************
    // Arbitration: highest level, lowest index on a tie
    // ************************************************************
    logic       win_found;
    logic [5:0] win_idx;
    logic [3:0] win_level;

    always_comb
    begin
        win_found = 1'b0;
        win_idx   = 6'h00;
        win_level = 4'h0;
        // Walk downward so the lower index replaces equal levels
        for (int i = intvec_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (pend[i] &&
                (!win_found || level[i] >= win_level))
            begin
                win_found = 1'b1;
                win_idx   = 6'(i);
                win_level = level[i];
            end
        end
    end

    // Only internal sources may be routed to a transfer controller
    logic win_route;

    always_comb
    begin
        win_route = 1'b0;
        if (win_idx >= intvec_pkg::IDX_SWDT && win_idx < intvec_pkg::IDX_EXP)
            win_route = xfer_route_i[5'(win_idx - intvec_pkg::IDX_SWDT)];
    end

    intvec_pkg::vector_out_t gate_out;

    vector_gate u_gate
    (
        .found_i      (win_found),
        .idx_i        (win_idx),
        .level_i      (win_level),
        .mask_level_i (mask_level_i),
        .xfer_route_i (win_route),
        .out_o        (gate_out)
    );

    // ************************************************************
    // Registered outputs, refreshed from the gate every cycle except the one in which the core accepts the NMI
    // ************************************************************
    // Level sources that lose simply remain in pend and win later
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            core_irq_o    <= 1'b0;
            xfer_req_o    <= 1'b0;
            vector_num_o  <= 8'h00;
            vector_addr_o <= 16'h0000;
        end
        else if (nmi_taken)
        begin
            // Drop the request for one cycle while the NMI latch clears
            core_irq_o    <= 1'b0;
            xfer_req_o    <= 1'b0;
        end
        else
        begin
            core_irq_o    <= gate_out.issue_core;
            xfer_req_o    <= gate_out.issue_xfer;
            vector_num_o  <= gate_out.vector;
            vector_addr_o <= gate_out.address;
        end
    end

endmodule

// [tb/intvec_chk.sv]
// Port-level assertion checker for the interrupt vector block
`timescale 1ns/10ps
module intvec_chk
(
    input wire logic                        mclk_i,
    input wire logic                        rstn_i,
    input wire logic                        nmi_event_i,
    input wire logic [7:0]                  ext_pin_req_i,
    input wire logic [7:0]                  expansion_request_pin_n_i,
    input wire intvec_pkg::periph_req_t     periph_req_i,
    input wire logic [30:0]                 xfer_route_i,
    input wire intvec_pkg::prio_regs_t      priority_level_register_i,
    input wire logic [2:0]                  mask_level_i,
    input wire logic                        core_ack_i,
    input wire logic                        core_irq_o,
    input wire logic                        xfer_req_o,
    input wire logic [7:0]                  vector_num_o,
    input wire logic [15:0]                 vector_addr_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic        nmi_p_q;
    logic [30:0] act;
    logic        idle;
    logic        ack_nmi;
    assign act = periph_req_i.flag & periph_req_i.enable;
    assign idle = !(|ext_pin_req_i) && !(|act);
    assign ack_nmi = core_ack_i && core_irq_o && vector_num_o == 8'h07;
    // Mirror of the pending non-maskable request
    always_ff @(posedge mclk_i or negedge rstn_i)
        if (!rstn_i)
            nmi_p_q <= 1'b0;
        else if (nmi_event_i)
            nmi_p_q <= 1'b1;
        else if (ack_nmi)
            nmi_p_q <= 1'b0;
    a_addr_four_times: assert property (
        vector_addr_o == {6'h00, vector_num_o, 2'h0})
        else $error("vector address not four times vector");
    a_nmi_issue: assert property (nmi_p_q && !core_ack_i |=>
        core_irq_o && vector_num_o == 8'h07) else $error("nmi not issued");
    a_nmi_ack_drop: assert property (ack_nmi && !nmi_event_i |=>
        !core_irq_o && !xfer_req_o) else $error("nmi held after ack");
    a_idle_quiet: assert property (idle && &expansion_request_pin_n_i
        && !nmi_p_q |=> !core_irq_o && !xfer_req_o) else $error("spurious out");
    a_mask_all_high: assert property (
        mask_level_i == 3'h7 && !nmi_p_q
        |=> !core_irq_o && !xfer_req_o) else $error("request above mask 7");
    a_one_target: assert property (!(core_irq_o && xfer_req_o))
        else $error("request to core and transfer at once");
    a_xfer_routed: assert property (xfer_req_o |->
        $past(|(act & xfer_route_i))) else $error("transfer without route");
    a_pin_vector: assert property (expansion_request_pin_n_i == 8'hFE
        && idle && !nmi_p_q && priority_level_register_i[12][6:4] >
        mask_level_i |=> core_irq_o && vector_num_o == 8'h68)
        else $error("expansion pin 0 not issued");
endmodule
bind interrupt_vector_priority intvec_chk u_intvec_chk (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .nmi_event_i(nmi_event_i),
    .ext_pin_req_i(ext_pin_req_i),
    .expansion_request_pin_n_i(expansion_request_pin_n_i),
    .periph_req_i(periph_req_i), .xfer_route_i(xfer_route_i),
    .priority_level_register_i(priority_level_register_i),
    .mask_level_i(mask_level_i), .core_ack_i(core_ack_i),
    .core_irq_o(core_irq_o), .xfer_req_o(xfer_req_o),
    .vector_num_o(vector_num_o), .vector_addr_o(vector_addr_o));

// [tb/core_model.sv]
// Behavioural core that accepts the non-maskable request
`timescale 1ns/10ps
module core_model
(
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       slow_i,
    input  wire logic       irq_i,
    input  wire logic [7:0] vec_i,
    output logic            ack_o
);
    logic [1:0] wait_q;
    // Acknowledge at once or after three cycles
    always_ff @(posedge mclk_i or negedge rstn_i)
        if (!rstn_i)
        begin
            ack_o <= 1'b0;
            wait_q <= 2'h0;
        end
        else if (irq_i && vec_i == 8'h07 && !ack_o)
        begin
            ack_o <= wait_q == (slow_i ? 2'h3 : 2'h0);
            wait_q <= wait_q + 2'h1;
        end
        else
        begin
            ack_o <= 1'b0;
            wait_q <= 2'h0;
        end
endmodule

// [tb/tb.sv]
// Self-checking testbench for the interrupt vector block
`timescale 1ns/10ps
module tb;
    logic mclk_i, rstn_i, nmi, ack, irq, xfer, slow;
    logic [7:0] ext, exn, vec;
    logic [15:0] addr;
    logic [30:0] rt;
    logic [2:0] mask;
    intvec_pkg::periph_req_t pr;
    intvec_pkg::prio_regs_t prio;
    intvec_pkg::vector_out_t q[$];
    int mismatches, checks, cycles;
    event got_ev;
    always #4 mclk_i = ~mclk_i;
    interrupt_vector_priority u_interrupt_vector_priority (.mclk_i(mclk_i),
        .rstn_i(rstn_i), .nmi_event_i(nmi), .ext_pin_req_i(ext),
        .expansion_request_pin_n_i(exn), .periph_req_i(pr),
        .xfer_route_i(rt), .priority_level_register_i(prio),
        .mask_level_i(mask), .core_ack_i(ack), .core_irq_o(irq),
        .xfer_req_o(xfer), .vector_num_o(vec), .vector_addr_o(addr));
    core_model u_core_model (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .slow_i(slow), .irq_i(irq), .vec_i(vec),
        .ack_o(ack));
    // Vector of the lowest requesting pin, which wins at equal level
    function automatic logic [7:0] low_vec(input logic [7:0] b);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 7; i >= 0; i--)
            if (b[i])
                v = 8'(i + 16);
        return v;
    endfunction
    function automatic logic [7:0] vi(input int j);
        if (j < 2)
            return 8'(j + 24);
        if (j < 7)
            return 8'(j + 30);
        if (j < 15)
            return 8'(j + 33);
        if (j < 19)
            return 8'(j + 57);
        return 8'(j + 61);
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Note the outputs due one edge after the inputs changed
    task automatic eo(input logic c, input logic t, input logic [7:0] v);
        @(posedge mclk_i);
        #1;
        q.push_back('{c, t, v, {6'h00, v, 2'h0}});
        ->got_ev;
    endtask
    task automatic cmp_out(input intvec_pkg::vector_out_t e);
        intvec_pkg::vector_out_t s;
        s = '{irq, xfer, vec, addr};
        if (!(e.issue_core | e.issue_xfer))
            s[23:0] = e[23:0];
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("wrong value outputs exp %h got %h", e, s);
        end
    endtask
    always @(got_ev)
        cmp_out(q.pop_front());
    always @(posedge mclk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            test_done();
        end
    end
    initial
    begin
        int k;
        logic [2:0] m, hi;
        logic [7:0] r8;
        logic [30:0] r;
        {mclk_i, rstn_i, nmi, slow, ext, rt, mask, pr, prio} = '0;
        {exn, mismatches, checks, cycles} = {8'hFF, 96'h0};
        void'($urandom(32'hCB23E490));
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1;
        prio <= {13{8'h77}};
        mask <= 3'h6;
        for (k = 0; k < 47; k++)
        begin
            @(posedge mclk_i);
            ext <= k < 8 ? 8'h01 << k : 8'h00;
            exn <= k > 7 && k < 16 ? ~(8'h01 << (k - 8)) : 8'hFF;
            pr <= '{k > 15 ? 31'h1 << (k - 16) : 31'h0, 31'h7FFFFFFF};
            r8 = k < 16 ? 8'(k + (k < 8 ? 16 : 96)) : vi(k - 16);
            eo(1'b1, 1'b0, r8);
        end
        $display("test vectors done");
        for (k = 0; k < 4; k++)
        begin
            r = 31'($urandom);
            @(posedge mclk_i);
            pr <= '{r, ~r};
            eo(1'b0, 1'b0, 8'h00);
        end
        for (k = 0; k < 16; k++)
        begin
            m = 3'($urandom);
            hi = k < 8 ? 3'(k) : ~3'(k);
            @(posedge mclk_i);
            prio[12] <= {1'b0, 3'(k), 1'b0, ~3'(k)};
            exn <= k < 8 ? 8'hFE : 8'hEF;
            mask <= m;
            r8 = k < 8 ? 8'h68 : 8'h6C;
            eo(hi > m, 1'b0, r8);
        end
        $display("test levels done");
        @(posedge mclk_i);
        {prio, mask, exn} <= {{13{8'h55}}, 3'h0, 8'hFF};
        for (k = 0; k < 6; k++)
        begin
            r8 = 8'($urandom) | 8'h80;
            @(posedge mclk_i);
            ext <= r8;
            eo(1'b1, 1'b0, low_vec(r8));
            r8 = r8 & (r8 - 8'h01);
            @(posedge mclk_i);
            ext <= r8;
            eo(r8 != 8'h00, 1'b0, low_vec(r8));
        end
        @(posedge mclk_i);
        {ext, exn} <= {8'h00, 8'hFE};
        pr <= '{31'h1 << 19, 31'h7FFFFFFF};
        eo(1'b1, 1'b0, 8'h50);
        @(posedge mclk_i);
        prio[12] <= 8'h65;
        eo(1'b1, 1'b0, 8'h68);
        k = $urandom_range(30);
        @(posedge mclk_i);
        {exn, rt} <= {8'hFF, 31'h7FFFFFFF};
        pr <= '{31'h1 << k, 31'h7FFFFFFF};
        eo(1'b0, 1'b1, vi(k));
        @(posedge mclk_i);
        mask <= 3'h5;
        eo(1'b0, 1'b0, 8'h00);
        $display("test order done");
        for (k = 0; k < 2; k++)
        begin
            @(posedge mclk_i);
            {pr, mask, slow, nmi} <= {62'h0, 3'h7, k[0], 1'b1};
            @(posedge mclk_i);
            nmi <= 1'b0;
            eo(1'b1, 1'b0, 8'h07);
            while (ack !== 1'b1)
                @(posedge mclk_i);
            eo(1'b0, 1'b0, 8'h07);
        end
        $display("test nmi done");
        @(posedge mclk_i);
        test_done();
    end
endmodule
